// ==== inc/intc_pkg.sv ====
// Constants, register map and state type for the interrupt latch and enable unit.
package intc_pkg;

	localparam int              NUM_SRC      = 40;
	localparam int              IDX_W        = 6;
	localparam int              NEST_W       = 4;
	localparam int              LANES        = 5;

	localparam logic [7:0]      ADDR_PEND_B0 = 8'h3c;
	localparam logic [7:0]      ADDR_PEND_B1 = 8'h3d;
	localparam logic [7:0]      ADDR_PEND_B2 = 8'h2e;
	localparam logic [7:0]      ADDR_PEND_B3 = 8'h2f;
	localparam logic [7:0]      ADDR_PEND_B4 = 8'h2b;
	localparam logic [7:0]      ADDR_EN_B0   = 8'h3a;
	localparam logic [7:0]      ADDR_EN_B1   = 8'h3b;
	localparam logic [7:0]      ADDR_EN_B2   = 8'h2c;
	localparam logic [7:0]      ADDR_EN_B3   = 8'h2d;
	localparam logic [7:0]      ADDR_EN_B4   = 8'h2a;
	localparam logic [2:0]      LANE_NONE    = 3'h7;

	localparam int              IMF_BIT      = 0;
	localparam int              WDT_IDX      = 2;
	localparam logic [39:0]     PEND_MASK    = 40'hff_ffff_fffc;
	localparam logic [39:0]     EN_MASK      = 40'hff_ffff_fff9;
	localparam logic [39:0]     PSEUDO_MASK  = 40'h00_0000_0004;
	localparam logic [39:0]     PEND_RST     = 40'h00_0000_0000;
	localparam logic [39:0]     EN_RST       = 40'h00_0000_0000;
	localparam logic [NEST_W-1:0] NEST_RST   = 4'h0;

	localparam logic [1:0]      NEST_CMD_CLR = 2'h1;
	localparam logic [1:0]      NEST_CMD_DEC = 2'h2;
	localparam logic [1:0]      NEST_RD_IDLE = 2'h0;
	localparam logic [1:0]      NEST_RD_BUSY = 2'h1;

	localparam int              CLK_PERIOD_NS = 10;
	localparam int              MCYC_NS       = 200;
	localparam int              MCYC_CLKS_I   =
		(MCYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]      MCYC_LAST     = 8'(MCYC_CLKS_I - 1);
	localparam logic [3:0]      ACCEPT_MCYC   = 4'hc;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ACCEPT = 2'b10
	} accept_state_t;

endpackage

// ==== rtl/interrupt_latch_enable_unit.sv ====
// Pending latches, enable flags, nesting counter and acceptance sequencer.
`timescale 1ns/10ps
module interrupt_latch_enable_unit (
	input  wire logic                        CLK_SYS_I,
	input  wire logic                        SRST_I,
	input  wire logic [intc_pkg::NUM_SRC-1:0] SRC_REQ_I,
	input  wire logic [7:0]                  SFR_ADDR_I,
	input  wire logic                        SFR_WR_I,
	input  wire logic [7:0]                  SFR_WDATA_I,
	input  wire logic                        EI_I,
	input  wire logic                        DI_I,
	input  wire logic                        MASKABLE_RETURN_INSTR_I,
	input  wire logic                        NONMASKABLE_RETURN_INSTR_I,
	input  wire logic                        ACCEPT_I,
	input  wire logic                        PNMI_ACCEPT_I,
	output logic                             IRQ_REQ_O,
	output logic [intc_pkg::IDX_W-1:0]       IRQ_INDEX_O,
	output logic                             IRQ_PSEUDO_O,
	output logic                             IMF_O,
	output logic                             SAVED_IMF_O,
	output logic                             ENTRY_READY_O,
	output logic [7:0]                       SFR_RDATA_O
);
	import intc_pkg::*;

	accept_state_t          state_q;
	accept_state_t          state_d;
	logic [NUM_SRC-1:0]     pend_q;
	logic [NUM_SRC-1:0]     pend_d;
	logic [NUM_SRC-1:0]     en_q;
	logic [NUM_SRC-1:0]     en_d;
	logic [NEST_W-1:0]      nest_q;
	logic [NEST_W-1:0]      nest_d;
	logic                   nmi_imf_q;
	logic                   nmi_imf_d;
	logic                   saved_imf_q;
	logic                   saved_imf_d;
	logic [7:0]             mc_cnt_q;
	logic [7:0]             mc_cnt_d;
	logic [3:0]             mc_num_q;
	logic [3:0]             mc_num_d;
	logic                   irq_req_q;
	logic                   irq_req_d;
	logic [IDX_W-1:0]       irq_idx_q;
	logic [IDX_W-1:0]       irq_idx_d;
	logic                   irq_pseudo_q;
	logic                   irq_pseudo_d;
	logic                   entry_q;
	logic                   entry_d;
	logic [7:0]             rdata_q;
	logic [7:0]             rdata_d;

	logic [2:0]             pend_lane;
	logic [2:0]             en_lane;
	logic [NUM_SRC-1:0]     wdata40;
	logic [NUM_SRC-1:0]     elig;
	logic                   take_mask;
	logic                   take_pnmi;
	logic                   take_any;

	function automatic logic [2:0] lane_of(input logic [7:0] addr,
		input logic pend);
		logic [2:0] lane;
		lane = LANE_NONE;
		if (pend) begin
			case (addr)
				ADDR_PEND_B0: lane = 3'h0;
				ADDR_PEND_B1: lane = 3'h1;
				ADDR_PEND_B2: lane = 3'h2;
				ADDR_PEND_B3: lane = 3'h3;
				ADDR_PEND_B4: lane = 3'h4;
				default:      lane = LANE_NONE;
			endcase
		end else begin
			case (addr)
				ADDR_EN_B0: lane = 3'h0;
				ADDR_EN_B1: lane = 3'h1;
				ADDR_EN_B2: lane = 3'h2;
				ADDR_EN_B3: lane = 3'h3;
				ADDR_EN_B4: lane = 3'h4;
				default:    lane = LANE_NONE;
			endcase
		end
		return lane;
	endfunction

	function automatic logic [NUM_SRC-1:0] lane_mask(input logic [2:0] lane);
		logic [NUM_SRC-1:0] m;
		m = '0;
		if (lane < 3'(LANES)) begin
			m = 40'h00_0000_00ff << {lane, 3'h0};
		end
		return m;
	endfunction

	function automatic logic [7:0] lane_byte(input logic [NUM_SRC-1:0] v,
		input logic [2:0] lane);
		logic [7:0] b;
		b = 8'h00;
		if (lane < 3'(LANES)) begin
			b = v[{lane, 3'h0} +: 8];
		end
		return b;
	endfunction

	// Scanning from the top down leaves the lowest set index as the winner.
	function automatic logic [IDX_W-1:0] first_set(
		input logic [NUM_SRC-1:0] v);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction

	assign pend_lane = lane_of(SFR_ADDR_I, 1'b1);
	assign en_lane   = lane_of(SFR_ADDR_I, 1'b0);
	assign wdata40   = {LANES{SFR_WDATA_I}};

	// The watchdog latch bypasses both enable levels.
	assign elig = pend_q & ((en_q & {NUM_SRC{en_q[IMF_BIT]}}) | PSEUDO_MASK);

	// Core-internal traps outrank the watchdog, so they win a tie.
	assign take_pnmi = (state_q == ST_IDLE) && PNMI_ACCEPT_I;
	assign take_mask = (state_q == ST_IDLE) && ACCEPT_I && irq_req_q &&
		!PNMI_ACCEPT_I;
	assign take_any  = take_pnmi || take_mask;

	always_comb begin
		pend_d      = pend_q;
		en_d        = en_q;
		nest_d      = nest_q;
		nmi_imf_d   = nmi_imf_q;
		saved_imf_d = saved_imf_q;

		if (SFR_WR_I && (pend_lane != LANE_NONE)) begin
			pend_d = pend_q & ~(lane_mask(pend_lane) & ~wdata40);
			if (pend_lane == 3'h0) begin
				if (SFR_WDATA_I[1:0] == NEST_CMD_CLR) begin
					nest_d = '0;
				end else if (SFR_WDATA_I[1:0] == NEST_CMD_DEC) begin
					nest_d = nest_q - 4'h1;
				end
			end
		end
		if (SFR_WR_I && (en_lane != LANE_NONE)) begin
			en_d = ((en_q & ~lane_mask(en_lane)) |
				(wdata40 & lane_mask(en_lane))) & EN_MASK;
		end

		if (EI_I) begin
			en_d[IMF_BIT] = 1'b1;
		end else if (DI_I) begin
			en_d[IMF_BIT] = 1'b0;
		end

		if (MASKABLE_RETURN_INSTR_I) begin
			en_d[IMF_BIT] = 1'b1;
			nest_d        = nest_d - 4'h1;
		end else if (NONMASKABLE_RETURN_INSTR_I) begin
			en_d[IMF_BIT] = nmi_imf_q;
			nest_d        = nest_d - 4'h1;
		end

		if (take_any) begin
			saved_imf_d   = en_q[IMF_BIT];
			en_d[IMF_BIT] = 1'b0;
			nest_d        = nest_d + 4'h1;
			if (take_pnmi || irq_pseudo_q) begin
				nmi_imf_d = en_q[IMF_BIT];
			end
		end
		if (take_mask) begin
			pend_d[irq_idx_q] = 1'b0;
		end

		// A fresh request overrides any clear in the same cycle.
		pend_d = pend_d | (SRC_REQ_I & PEND_MASK);
	end

	// Acceptance runs a fixed twelve machine cycles from the acceptance edge.
	always_comb begin
		state_d  = state_q;
		mc_cnt_d = mc_cnt_q;
		mc_num_d = mc_num_q;
		entry_d  = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (take_any) begin
					state_d  = ST_ACCEPT;
					mc_cnt_d = '0;
					mc_num_d = '0;
				end
			end
			ST_ACCEPT: begin
				if (mc_cnt_q == MCYC_LAST) begin
					mc_cnt_d = '0;
					mc_num_d = mc_num_q + 4'h1;
					if (mc_num_q == ACCEPT_MCYC - 4'h1) begin
						state_d = ST_IDLE;
						entry_d = 1'b1;
					end
				end else begin
					mc_cnt_d = mc_cnt_q + 8'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_comb begin
		irq_req_d    = (state_d == ST_IDLE) && (|elig) && !take_any;
		irq_idx_d    = first_set(elig);
		irq_pseudo_d = (first_set(elig) == IDX_W'(WDT_IDX));
		rdata_d      = 8'h00;
		if (pend_lane != LANE_NONE) begin
			rdata_d = lane_byte(pend_q, pend_lane);
			if (pend_lane == 3'h0) begin
				rdata_d[1:0] = (nest_q == '0) ? NEST_RD_IDLE :
					NEST_RD_BUSY;
			end
		end else if (en_lane != LANE_NONE) begin
			rdata_d = lane_byte(en_q, en_lane);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			state_q      <= ST_IDLE;
			pend_q       <= PEND_RST;
			en_q         <= EN_RST;
			nest_q       <= NEST_RST;
			nmi_imf_q    <= 1'b0;
			saved_imf_q  <= 1'b0;
			mc_cnt_q     <= '0;
			mc_num_q     <= '0;
			irq_req_q    <= 1'b0;
			irq_idx_q    <= '0;
			irq_pseudo_q <= 1'b0;
			entry_q      <= 1'b0;
			rdata_q      <= 8'h00;
		end else begin
			state_q      <= state_d;
			pend_q       <= pend_d;
			en_q         <= en_d;
			nest_q       <= nest_d;
			nmi_imf_q    <= nmi_imf_d;
			saved_imf_q  <= saved_imf_d;
			mc_cnt_q     <= mc_cnt_d;
			mc_num_q     <= mc_num_d;
			irq_req_q    <= irq_req_d;
			irq_idx_q    <= irq_idx_d;
			irq_pseudo_q <= irq_pseudo_d;
			entry_q      <= entry_d;
			rdata_q      <= rdata_d;
		end
	end

	assign IRQ_REQ_O     = irq_req_q;
	assign IRQ_INDEX_O   = irq_idx_q;
	assign IRQ_PSEUDO_O  = irq_pseudo_q;
	assign IMF_O         = en_q[IMF_BIT];
	assign SAVED_IMF_O   = saved_imf_q;
	assign ENTRY_READY_O = entry_q;
	assign SFR_RDATA_O   = rdata_q;

endmodule

// ==== testbench/cpu_core_model.sv ====
// Behavioural core that takes presented requests and returns from them.
`timescale 1ns/10ps
module cpu_core_model (
	input  wire logic clk_i,
	input  wire logic en_i,
	input  wire logic slow_i,
	input  wire logic irq_req_i,
	input  wire logic pseudo_i,
	input  wire logic ready_i,
	output logic      accept_o,
	output logic      maskable_return_instr_o,
	output logic      nonmaskable_return_instr_o
);
	logic psd;
	int   n;
	initial begin
		{accept_o, maskable_return_instr_o, nonmaskable_return_instr_o} = 3'h0;
		forever begin
			@(posedge clk_i) #1;
			if (slow_i && en_i && irq_req_i)
				repeat (8) @(posedge clk_i) #1;
			if (en_i && irq_req_i) begin
				accept_o = 1'b1;
				psd = pseudo_i;
				@(posedge clk_i) #1;
				accept_o = 1'b0;
				for (n = 0; n < 300 && !ready_i; n++)
					@(posedge clk_i) #1;
				maskable_return_instr_o = !psd;
				nonmaskable_return_instr_o = psd;
				@(posedge clk_i) #1;
				{maskable_return_instr_o, nonmaskable_return_instr_o} = 2'h0;
			end
		end
	end
endmodule

// ==== testbench/ilu_props.sv ====
// Port checker for the interrupt latch and enable unit.
`timescale 1ns/10ps
module ilu_props (
	input wire logic       CLK_SYS_I,
	input wire logic       SRST_I,
	input wire logic       EI_I,
	input wire logic       MASKABLE_RETURN_INSTR_I,
	input wire logic       NONMASKABLE_RETURN_INSTR_I,
	input wire logic       ACCEPT_I,
	input wire logic       PNMI_ACCEPT_I,
	input wire logic       IRQ_REQ_O,
	input wire logic [5:0] IRQ_INDEX_O,
	input wire logic       IRQ_PSEUDO_O,
	input wire logic       IMF_O,
	input wire logic       SAVED_IMF_O,
	input wire logic       ENTRY_READY_O
);
	logic busy_q;
	logic take;
	// Accepts during a running sequence are ignored, so they start nothing.
	assign take = !busy_q && (PNMI_ACCEPT_I || ACCEPT_I && IRQ_REQ_O);
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			busy_q <= 1'b0;
		else if (take)
			busy_q <= 1'b1;
		else if (ENTRY_READY_O)
			busy_q <= 1'b0;
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (SRST_I);
	// The pulse is registered at the 240th edge, so it is sampled one later.
	property p_entry; take |-> ##241 ENTRY_READY_O; endproperty
	a_entry: assert property (p_entry) else $error("entry late");
	property p_pulse; ENTRY_READY_O |=> !ENTRY_READY_O; endproperty
	a_pulse: assert property (p_pulse) else $error("entry long");
	property p_save; take |=> !IMF_O && SAVED_IMF_O == $past(IMF_O); endproperty
	a_save: assert property (p_save) else $error("flag save");
	property p_quiet; take |=> !IRQ_REQ_O [*8]; endproperty
	a_quiet: assert property (p_quiet) else $error("request kept");
	property p_maskable_return_instr; MASKABLE_RETURN_INSTR_I && !take |=> IMF_O; endproperty
	a_maskable_return_instr: assert property (p_maskable_return_instr) else $error("return flag");
	property p_ei; EI_I && !MASKABLE_RETURN_INSTR_I && !NONMASKABLE_RETURN_INSTR_I && !take |=> IMF_O; endproperty
	a_ei: assert property (p_ei) else $error("enable flag");
	property p_gate; IRQ_REQ_O && !IRQ_PSEUDO_O |-> $past(IMF_O); endproperty
	a_gate: assert property (p_gate) else $error("masked request");
	property p_wdt; IRQ_REQ_O && IRQ_INDEX_O == 6'h2 |-> IRQ_PSEUDO_O; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog kind");
endmodule
bind interrupt_latch_enable_unit ilu_props ilu_props_i (
	.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .EI_I(EI_I), .MASKABLE_RETURN_INSTR_I(MASKABLE_RETURN_INSTR_I),
	.NONMASKABLE_RETURN_INSTR_I(NONMASKABLE_RETURN_INSTR_I), .ACCEPT_I(ACCEPT_I), .PNMI_ACCEPT_I(PNMI_ACCEPT_I),
	.IRQ_REQ_O(IRQ_REQ_O), .IRQ_INDEX_O(IRQ_INDEX_O),
	.IRQ_PSEUDO_O(IRQ_PSEUDO_O), .IMF_O(IMF_O), .SAVED_IMF_O(SAVED_IMF_O),
	.ENTRY_READY_O(ENTRY_READY_O));

// ==== testbench/test_interrupt_latch_enable_unit.sv ====
// Self-checking bench for the interrupt latch and enable unit.
`timescale 1ns/10ps
module test_interrupt_latch_enable_unit;
	logic        clk, srst, wr_s, ei, di, pnmi, cpu_en, slow;
	logic        acc, maskable_return_instr, nonmaskable_return_instr, irq, psd, master_enable_flag, simf, rdy;
	logic [39:0] src;
	logic [7:0]  addr, wd, rdata;
	logic [5:0]  idx;
	int          err_count, tests_run;
	interrupt_latch_enable_unit interrupt_latch_enable_unit_i (
		.CLK_SYS_I(clk), .SRST_I(srst), .SRC_REQ_I(src), .SFR_ADDR_I(addr),
		.SFR_WR_I(wr_s), .SFR_WDATA_I(wd), .EI_I(ei), .DI_I(di),
		.MASKABLE_RETURN_INSTR_I(maskable_return_instr), .NONMASKABLE_RETURN_INSTR_I(nonmaskable_return_instr), .ACCEPT_I(acc), .PNMI_ACCEPT_I(pnmi),
		.IRQ_REQ_O(irq), .IRQ_INDEX_O(idx), .IRQ_PSEUDO_O(psd), .IMF_O(master_enable_flag),
		.SAVED_IMF_O(simf), .ENTRY_READY_O(rdy), .SFR_RDATA_O(rdata));
	cpu_core_model cpu_core_model_i (.clk_i(clk), .en_i(cpu_en),
		.slow_i(slow), .irq_req_i(irq), .pseudo_i(psd), .ready_i(rdy),
		.accept_o(acc), .maskable_return_instr_o(maskable_return_instr), .nonmaskable_return_instr_o(nonmaskable_return_instr));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic step;
		@(posedge clk) #1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr_s = 1'b1;
		step;
		wr_s = 1'b0;
		step;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		step;
		chk(rdata, e);
	endtask
	task automatic req(input logic [39:0] v);
		src = v;
		step;
		src = 40'h0;
		step;
	endtask
	task automatic wait_rdy;
		int n;
		for (n = 0; n < 300 && rdy !== 1'b1; n++)
			step;
		if (n == 300) begin
			err_count++;
			$display("[FAIL] %0t no entry", $time);
			print_verdict;
		end
	endtask
	// Kind and index are caught while presented; flags are judged at entry.
	task automatic svc(input logic [7:0] e, input logic [7:0] s);
		int n;
		logic [7:0] p;
		for (n = 0; n < 300 && irq !== 1'b1; n++)
			step;
		if (n == 300) begin
			err_count++;
			$display("[FAIL] %0t no request", $time);
			print_verdict;
		end
		p = {1'b0, psd, idx};
		wait_rdy;
		chk(p, e);
		chk({6'h0, master_enable_flag, simf}, s);
	endtask
	task automatic t_regs;
		rd(8'h3a, 8'h00);
		rd(8'h2a, 8'h00);
		rd(8'h3c, 8'h00);
		req(40'h80_0000_0020);
		rd(8'h3c, 8'h20);
		rd(8'h2b, 8'h80);
		wr(8'h2b, 8'hff);
		rd(8'h2b, 8'h80);
		addr = 8'h2b;
		wd = 8'h00;
		wr_s = 1'b1;
		src = 40'h02_0000_0000;
		step;
		wr_s = 1'b0;
		src = 40'h0;
		step;
		rd(8'h2b, 8'h02);
		wr(8'h2b, 8'h7d);
		rd(8'h2b, 8'h00);
		wr(8'h3c, 8'hdc);
		rd(8'h3c, 8'h00);
		wr(8'h2c, 8'ha5);
		rd(8'h2c, 8'ha5);
		wr(8'h3a, 8'hfe);
		rd(8'h3a, 8'hf8);
		rd(8'h00, 8'h00);
		wr(8'h3a, 8'h01);
		chk({7'h0, master_enable_flag}, 8'h01);
		di = 1'b1;
		step;
		di = 1'b0;
		step;
		chk({7'h0, master_enable_flag}, 8'h00);
	endtask
	task automatic t_accept;
		slow = 1'b1;
		wr(8'h3a, 8'h60);
		req(40'h60);
		chk({7'h0, irq}, 8'h00);
		ei = 1'b1;
		step;
		ei = 1'b0;
		cpu_en = 1'b1;
		svc(8'h05, 8'h01);
		step;
		chk({7'h0, master_enable_flag}, 8'h01);
		svc(8'h06, 8'h01);
		cpu_en = 1'b0;
		repeat (3) step;
		rd(8'h3c, 8'h00);
	endtask
	task automatic t_wdt(input logic en, input logic [7:0] s);
		slow = 1'b0;
		cpu_en = 1'b1;
		ei = en;
		di = !en;
		step;
		{ei, di} = 2'h0;
		req(40'h4);
		svc(8'h42, s);
		repeat (2) step;
		chk({7'h0, master_enable_flag}, s);
		cpu_en = 1'b0;
	endtask
	task automatic t_nest;
		repeat (2) begin
			pnmi = 1'b1;
			step;
			pnmi = 1'b0;
			wait_rdy;
			step;
		end
		wr(8'h3c, 8'hfe);
		rd(8'h3c, 8'h01);
		wr(8'h3c, 8'hfd);
		rd(8'h3c, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		srst = 1'b1;
		{wr_s, ei, di, pnmi, cpu_en, slow} = 6'h0;
		{src, addr, wd} = 56'h0;
		err_count = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		t_regs;
		t_accept;
		t_wdt(1'b0, 8'h00);
		t_wdt(1'b1, 8'h01);
		t_nest;
		print_verdict;
	end
endmodule
